// >>> hw/output_realign.sv
// output-divider realignment: request capture, qualification, one-shot, restart
`timescale 1ns/1ns
`default_nettype none
`include "realign_params.svh"
module output_realign (
  input  wire logic        clock,        // distribution-path clock, 20 MHz model
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic        realign_pin,  // external realignment request pin
  input  wire logic        digital_lock_detect, // first-loop lock status
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // wishbone write enable
  input  wire logic [3:0]  wb_adr_i,     // wishbone word address
  input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,     // wishbone write data
  output logic [31:0]      wb_dat_o,     // wishbone read data
  output logic             wb_ack_o,     // wishbone acknowledge
  output logic [5:0]       clk_out,      // outputs, two per pair
  output logic             holdover      // holdover request from lock loss
);
  import realign_pkg::*;

  // pair divider settings
  function automatic logic [`CNT_W-1:0] rise_count(input logic [`DLY_W-1:0] d);
    rise_count = `FIXED_RISE_CYC + `CNT_W'(d);
  endfunction : rise_count

  logic [`DIV_W-1:0] div_q   [`PAIRS];
  logic [`DLY_W-1:0] dly_q   [`PAIRS];
  logic [`DLY_W-1:0] act_dly_q [`PAIRS];
  logic [`PAIRS-1:0] hs_q, excl_q, pd_q;
  logic [7:0]        ctrl_q;
  logic              qualify_by_output, realign_polarity_invert, realign_enable;
  logic              auto_realign, fb_enable, first_loop_lock_detect_disable;
  logic [1:0]        fb_select;
  logic              wr, rd_ack;
  logic              auto_req;
  realign_state_t    state_q;  // sequencer state, also shown in status

  assign realign_enable                 = ctrl_q[0];
  assign qualify_by_output              = ctrl_q[1];
  assign realign_polarity_invert        = ctrl_q[2];
  assign auto_realign                   = ctrl_q[3];
  assign fb_enable                      = ctrl_q[4];
  assign fb_select                      = ctrl_q[6:5];
  assign first_loop_lock_detect_disable = ctrl_q[7];

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // bus ack: one cycle after request, dropped the cycle after
  always_ff @(posedge clock) begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // control register write
  always_ff @(posedge clock) begin
    if (rst)
      ctrl_q <= `CTRL_RESET;
    else if (wr && wb_adr_i == `ADR_CTRL)
      ctrl_q <= wb_dat_i[7:0];
  end

  // pair registers: divide [10:0], delay [14:11], half [15], excl [16], pd [17]
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `PAIRS; i++) begin
        div_q[i] <= `DIV_RESET;
        dly_q[i] <= `DLY_RESET;
      end
      hs_q   <= '0;
      excl_q <= '0;
      pd_q   <= '0;
    end else if (wr) begin
      for (int i = 0; i < `PAIRS; i++) begin
        if (wb_adr_i == `ADR_PAIR0 + 4'(i)) begin
          div_q[i]  <= wb_dat_i[10:0];
          dly_q[i]  <= wb_dat_i[14:11];
          hs_q[i]   <= wb_dat_i[15];
          excl_q[i] <= wb_dat_i[16];
          pd_q[i]   <= wb_dat_i[17];
        end
      end
    end
  end

  // auto request on pair write, and always on calibration write
  always_ff @(posedge clock) begin
    if (rst)
      auto_req <= 1'b0;
    else
      auto_req <= wr && ((auto_realign && wb_adr_i >= `ADR_PAIR0 &&
                          wb_adr_i <= `ADR_PAIR2)
                         || wb_adr_i == `ADR_CAL);
  end

  // read mux
  always_ff @(posedge clock) begin
    if (rst)
      wb_dat_o <= '0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        `ADR_CTRL:   wb_dat_o <= {24'h0, ctrl_q};
        `ADR_STATUS: wb_dat_o <= {27'h0, holdover, digital_lock_detect,
                                  state_q};
        `ADR_PAIR0, `ADR_PAIR1, `ADR_PAIR2: begin
          wb_dat_o <= '0;
          for (int i = 0; i < `PAIRS; i++)
            if (wb_adr_i == `ADR_PAIR0 + 4'(i))
              wb_dat_o <= {14'h0, pd_q[i], excl_q[i], hs_q[i], dly_q[i], div_q[i]};
        end
        default:     wb_dat_o <= '0;
      endcase
    end
  end

  // request capture: pin xor polarity, registered, either edge taken as a request
  logic req_lvl_q, req_prev_q, req_edge;
  always_ff @(posedge clock) begin
    if (rst) begin
      req_lvl_q  <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      req_lvl_q  <= realign_pin ^ realign_polarity_invert;
      req_prev_q <= req_lvl_q;
    end
  end
  // any toggle counts, so no pulse width is needed
  assign req_edge = (req_lvl_q != req_prev_q) || auto_req;

  // qualifying output selection and falling-edge detect
  logic [5:0] outs;
  logic       qual_clk, qual_prev_q, qual_fall;
  assign qual_clk  = (fb_select == `SEL_PAIR_FOUR) ? outs[4] :
                     (fb_select == `SEL_PAIR_TWO)  ? outs[2] : outs[0];
  assign qual_fall = qual_prev_q && !qual_clk;
  always_ff @(posedge clock) begin
    if (rst)
      qual_prev_q <= 1'b0;
    else
      qual_prev_q <= qual_clk;
  end

  // sequencer
  logic [1:0]     edges_q;
  logic           cnt_load, low_load, rise_load, low_done, shot_end, rise_done;
  logic [`CNT_W-1:0] cnt_val;
  logic [`PAIRS-1:0] hold_q, grp_q;
  logic [`CNT_W-1:0] rise_q [`PAIRS];

  delay_counter seq_cnt (
    .clock (clock),
    .rst   (rst),
    .load  (cnt_load),
    .count (cnt_val),
    .done  (shot_end)
  );
  delay_counter low_cnt (
    .clock (clock),
    .rst   (rst),
    .load  (low_load),
    .count (`FIXED_LOW_CYC),
    .done  (low_done)
  );

  assign cnt_load  = (state_q == st_wait && shot_end) ||
                     (state_q == st_qual && edges_q == `QUAL_EDGES - 2'h1 && qual_fall) ||
                     (state_q == st_idle && req_edge && realign_enable &&
                      !(qualify_by_output && fb_enable));
  assign cnt_val   = (state_q == st_wait) ? `SHOT_WIDTH_CYC : `SHOT_DELAY_CYC;
  assign low_load  = state_q == st_wait && shot_end;
  assign rise_load = state_q == st_shot && shot_end;
  assign rise_done = state_q == st_rise && grp_q == '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= st_idle;
      edges_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          edges_q <= '0;
          if (req_edge && realign_enable) begin
            if (qualify_by_output && fb_enable)
              state_q <= st_qual;
            else
              state_q <= st_wait;
          end
        end
        st_qual: if (qual_fall) begin
          edges_q <= edges_q + 2'h1;
          if (edges_q == `QUAL_EDGES - 2'h1)
            state_q <= st_wait;
        end
        st_wait:  if (shot_end) state_q <= st_shot;
        st_shot:  if (shot_end) state_q <= st_rise;
        st_rise:  if (rise_done) state_q <= st_idle;
        default:  state_q <= st_idle;
      endcase
    end
  end

  // per-pair hold and restart counts
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_q <= '0;
      grp_q  <= '0;
      for (int i = 0; i < `PAIRS; i++) begin
        rise_q[i]    <= '0;
        act_dly_q[i] <= `DLY_RESET;
      end
    end else begin
      for (int i = 0; i < `PAIRS; i++) begin
        if (low_done && !excl_q[i])
          hold_q[i] <= 1'b1;
        if (rise_load && !excl_q[i]) begin
          act_dly_q[i] <= dly_q[i];
          rise_q[i]    <= rise_count(dly_q[i]);
          grp_q[i]     <= 1'b1;
        end else if (grp_q[i]) begin
          if (rise_q[i] == `CNT_W'(1)) begin
            grp_q[i]  <= 1'b0;
            hold_q[i] <= 1'b0;
          end
          rise_q[i] <= rise_q[i] - `CNT_W'(1);
        end
      end
    end
  end

  // dividers; pair power-down also stops the pair
  for (genvar g = 0; g < `PAIRS; g++) begin : g_pair
    pair_divider div_u (
      .clock     (clock),
      .rst       (rst),
      .divide    (div_q[g]),
      .half_step (hs_q[g]),
      .hold_low  (hold_q[g] | pd_q[g]),
      .clk_out   (outs[2*g])
    );
    assign outs[2*g+1] = outs[2*g];
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (rst)
      clk_out <= '0;
    else
      clk_out <= outs;
  end

  // holdover on lost lock unless detection disabled
  always_ff @(posedge clock) begin
    if (rst)
      holdover <= 1'b0;
    else
      holdover <= !digital_lock_detect && !first_loop_lock_detect_disable;
  end
endmodule : output_realign
`default_nettype wire

// >>> inc/realign_params.svh
// timing counts, field widths and reset values for the output realignment block
`ifndef REALIGN_PARAMS_SVH
`define REALIGN_PARAMS_SVH

`define PAIRS           3
`define DIV_W           11
`define DLY_W           4
`define CNT_W           6
`define FIXED_LOW_CYC   6'h05
`define FIXED_RISE_CYC  6'h05
`define SHOT_DELAY_CYC  6'h03
`define SHOT_WIDTH_CYC  6'h03
`define QUAL_EDGES      2'h2
`define SEL_PAIR_TWO    2'h1
`define SEL_PAIR_FOUR   2'h2
`define DIV_RESET       11'h00c
`define DLY_RESET       4'h5

`define ADR_CTRL        4'h0
`define ADR_STATUS      4'h1
`define ADR_PAIR0       4'h2
`define ADR_PAIR1       4'h3
`define ADR_PAIR2       4'h4
`define ADR_CAL         4'h5

`define CTRL_RESET      8'h01

`endif

// >>> inc/realign_pkg.sv
// types shared by the realignment block
package realign_pkg;
  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_qual   = 3'h1,
    st_wait   = 3'h2,
    st_shot   = 3'h3,
    st_rise   = 3'h4
  } realign_state_t;
endpackage : realign_pkg

// >>> hw/pair_divider.sv
// one output-pair divider with half-step and forced-low hold
`timescale 1ns/1ns
`default_nettype none
`include "realign_params.svh"
module pair_divider (
  input  wire logic              clock,     // distribution-path clock
  input  wire logic              rst,       // synchronous reset
  input  wire logic [`DIV_W-1:0] divide,    // divide ratio, 1 or more
  input  wire logic              half_step, // add half a path period of delay
  input  wire logic              hold_low,  // force output low and restart
  output var  logic              clk_out    // divided output, both edges
);
  logic [`DIV_W-1:0] cnt_q;
  logic              ph_q;
  logic              hs_q;
  logic [`DIV_W-1:0] half;

  assign half = divide >> 1;

  // counter: output high for ceil(div/2), low for floor(div/2)
  always_ff @(posedge clock) begin
    if (rst || hold_low) begin
      cnt_q <= '0;
      ph_q  <= 1'b0;
    end else if (cnt_q >= divide - `DIV_W'(1)) begin
      cnt_q <= '0;
      ph_q  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + `DIV_W'(1);
      ph_q  <= (cnt_q + `DIV_W'(1)) < (divide - half);
    end
  end

  // half-step: retime on the falling edge, so it acts at once
  always_ff @(negedge clock) begin
    if (rst)
      hs_q <= 1'b0;
    else
      hs_q <= ph_q & ~hold_low;
  end

  assign clk_out = half_step ? hs_q : (ph_q & ~hold_low);
endmodule : pair_divider
`default_nettype wire

// >>> hw/delay_counter.sv
// down counter that flags when a loaded cycle count has elapsed
`timescale 1ns/1ns
`default_nettype none
`include "realign_params.svh"
module delay_counter (
  input  wire logic              clock, // distribution-path clock
  input  wire logic              rst,   // synchronous reset
  input  wire logic              load,  // start a count
  input  wire logic [`CNT_W-1:0] count, // cycles to wait, 1 or more
  output logic                   done   // one-cycle pulse at end of count
);
  logic [`CNT_W-1:0] left_q;
  logic              run_q;

  // run until the remaining count reaches one
  always_ff @(posedge clock) begin
    if (rst) begin
      left_q <= '0;
      run_q  <= 1'b0;
    end else if (load) begin
      left_q <= count;
      run_q  <= 1'b1;
    end else if (run_q) begin
      left_q <= left_q - `CNT_W'(1);
      run_q  <= left_q > `CNT_W'(1);
    end
  end

  assign done = run_q && left_q == `CNT_W'(1);
endmodule : delay_counter
`default_nettype wire

// >>> tb/realign_checker_assertions.sv
// port-level checks for the output realignment block
`timescale 1ns/1ns
`default_nettype none
module realign_checker (
  input wire logic        clock,               // path clock
  input wire logic        rst,                 // sync reset
  input wire logic        digital_lock_detect, // first-loop lock
  input wire logic        wb_cyc_i,            // bus cycle
  input wire logic        wb_stb_i,            // bus strobe
  input wire logic [31:0] wb_dat_o,            // read data
  input wire logic        wb_ack_o,            // acknowledge
  input wire logic [5:0]  clk_out,             // outputs
  input wire logic        holdover             // holdover request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // an unanswered request, and a lock held for two samples
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_locked;
    digital_lock_detect [*2];
  endsequence
  property p_ack_lat;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // read data may only move together with an acknowledge
  property p_dat_hold;
    !wb_ack_o && !$past(rst) |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  property p_pair_tie;
    clk_out[0] == clk_out[1] && clk_out[2] == clk_out[3] && clk_out[4] == clk_out[5];
  endproperty
  a_pair_tie: assert property (p_pair_tie) else $error("pair outputs differ");
  property p_lock_clear;
    s_locked |=> !holdover;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("holdover while locked");
  property p_hold_cause;
    $rose(holdover) |-> !$past(digital_lock_detect);
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("holdover without lock loss");
  // reset must not be masked by the default disable
  property p_reset;
    disable iff (1'b0) rst |=> clk_out == 6'h00 && !wb_ack_o && !holdover;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not quiet after reset");
endmodule : realign_checker
bind output_realign realign_checker u_chk (.clock(clock), .rst(rst),
  .digital_lock_detect(digital_lock_detect), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clk_out(clk_out), .holdover(holdover));
`default_nettype wire

// >>> tb/realign_host.sv
// host-side model: realignment pin and first-loop lock source
`timescale 1ns/1ns
`default_nettype none
module realign_host (
  input  wire logic clock,  // path clock
  output var  logic pin,    // realignment request level
  output var  logic locked  // first-loop lock level
);
  initial begin
    pin = 1'b0;
    locked = 1'b1;
  end
  // any level change is a request; its width is left to the one-shot
  task tog();
    @(posedge clock);
    pin <= ~pin;
  endtask : tog
  task lock(input logic v);
    @(posedge clock);
    locked <= v;
  endtask : lock
endmodule : realign_host
`default_nettype wire

// >>> tb/dynamic_output_delay_realign_bench.sv
// self-checking bench for the output realignment block
`timescale 1ns/1ns
`default_nettype none
`include "realign_params.svh"
module dynamic_output_delay_realign_bench;
  logic        clock, rst, pin, locked, cyc, stb, we, ack, hold;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  clk_out;
  int          errors, num_checks, r5, r9, r;
  output_realign dut (.clock(clock), .rst(rst), .realign_pin(pin),
    .digital_lock_detect(locked), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .clk_out(clk_out), .holdover(hold));
  realign_host host (.clock(clock), .pin(pin), .locked(locked));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task end_of_test();
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask : bus
  // watch pair one for a stop-and-restart; pair zero must never stall
  task watch(output int rise);
    int low, gap, gmax, i;
    logic p0;
    rise = -1;
    low = 0;
    gap = 0;
    gmax = 0;
    i = 0;
    p0 = clk_out[0];
    repeat (90) begin
      @(posedge clock);
      if (clk_out[2] === 1'b0) low++;
      else begin
        if (low >= 10 && rise < 0) rise = i;
        low = 0;
      end
      gap = (clk_out[0] === p0) ? gap + 1 : 0;
      gmax = (gap > gmax) ? gap : gmax;
      p0 = clk_out[0];
      i++;
    end
    chk("excluded pair gap", 1, gmax <= 12);
  endtask : watch
  // main sequence
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(0, `ADR_CTRL, 0);
    chk("ctrl reset", `CTRL_RESET, q);
    bus(0, `ADR_PAIR0, 0);
    chk("pair0 reset", {17'h0, `DLY_RESET, `DIV_RESET}, q);
    bus(1, 4'hf, 32'h1);
    bus(0, 4'hf, 0);
    chk("unmapped", 0, q);
    bus(1, `ADR_PAIR0, 32'h1280c);
    bus(1, `ADR_PAIR2, 32'h1a80c);
    bus(1, `ADR_PAIR1, 32'h2802);
    bus(0, `ADR_PAIR1, 0);
    chk("pair1", 32'h2802, q);
    host.tog();
    watch(r5);
    chk("restart seen", 1, r5 >= 0);
    bus(1, `ADR_PAIR1, 32'h4802);
    host.tog();
    watch(r9);
    chk("delay step", 4, r9 - r5);
    bus(1, `ADR_CTRL, 32'h05);
    watch(r);
    chk("polarity request", 1, r >= 0);
    bus(1, `ADR_CTRL, 32'h04);
    host.tog();
    watch(r);
    chk("disabled", 32'hffffffff, r);
    bus(1, `ADR_CTRL, 32'h0d);
    watch(r);
    bus(1, `ADR_PAIR1, 32'h2802);
    watch(r);
    chk("auto request", 1, r >= 0);
    bus(1, `ADR_CTRL, 32'h05);
    bus(1, `ADR_CAL, 32'h0);
    watch(r);
    chk("calibration request", 1, r >= 0);
    // half-step alone must not restart the pair; then delay 5 and a request
    bus(1, `ADR_PAIR1, 32'ha802);
    watch(r);
    chk("half step only", 32'hffffffff, r);
    host.tog();
    watch(r);
    chk("backward step", 1, r >= 0);
    bus(1, `ADR_PAIR1, 32'hb802);
    bus(0, `ADR_PAIR1, 0);
    chk("table entry", 32'hb802, q);
    bus(1, `ADR_CTRL, 32'h57);
    host.tog();
    watch(r);
    chk("qualified later", 1, r > r5);
    bus(1, `ADR_PAIR1, 32'h3802);
    bus(1, `ADR_CTRL, 32'h37);
    host.tog();
    watch(r);
    chk("self qualified", 1, r >= 0);
    host.lock(1'b0);
    for (int i = 0; i < 8 && hold !== 1'b1; i++) @(posedge clock);
    chk("holdover", 1, hold);
    bus(0, `ADR_STATUS, 0);
    chk("status holdover", 1, q[4]);
    bus(1, `ADR_CTRL, 32'hb7);
    repeat (4) @(posedge clock);
    chk("holdover masked", 0, hold);
    host.lock(1'b1);
    end_of_test();
  end
endmodule : dynamic_output_delay_realign_bench
`default_nettype wire
